// File: vr_setpoint_map.vh
// Purpose: constants for the voltage-regulator setpoint command port
// Assumes: included by the port design and by its bench
// Notes: link field codes, register pointers and bus offsets live here
`ifndef VR_SETPOINT_MAP_VH
`define VR_SETPOINT_MAP_VH
// link frame layout (bits after start bit, msb first)
`define FRAME_BITS 5'h12
`define TX_BITS_ACK 4'h2
`define TX_BITS_READ 4'hB
`define ACK_CODE 2'h1
`define ALLCALL_A 4'hE
`define ALLCALL_B 4'hF
// command codes
`define CMD_FAST 5'h01
`define CMD_SLOW 5'h02
`define CMD_DECAY 5'h03
`define CMD_PSTATE 5'h04
`define CMD_PTR 5'h05
`define CMD_WRITE 5'h06
`define CMD_READ 5'h07
`define CMD_TRIM 5'h1F
// link register pointers
`define REG_VENDOR 8'h00
`define REG_PRODUCT 8'h01
`define REG_REV 8'h02
`define REG_PROTO 8'h05
`define REG_CAPAB 8'h06
`define REG_STAT1 8'h10
`define REG_STAT2 8'h11
`define REG_TZONE 8'h12
`define REG_IOUT0 8'h15
`define REG_IOUT1 8'h16
`define REG_HIST 8'h1C
`define REG_ICCMAX 8'h21
`define REG_TMAX 8'h22
`define REG_SRFAST 8'h24
`define REG_SRSLOW 8'h25
`define REG_VBOOT 8'h26
`define REG_VOUTMAX 8'h30
`define REG_SETTING 8'h31
`define REG_PSTATE 8'h32
`define REG_OFFSET 8'h33
`define REG_MULTI 8'h34
`define REG_POINTER 8'h35
// reset values
`define VBOOT_RST 8'h00
`define PROTO_VAL 8'h01
`define CAPAB_VAL 8'h81
// rate registers report mV/us as a byte
`define SRFAST_CODE 8'h14
`define SRSLOW_CODE 8'h05
// ramp timing
`define CLK_PERIOD_NS 100
`define STEP_MV 5
`define FAST_RATE_MV_PER_US 20
`define SLOW_RATE_MV_PER_US 5
// bus offsets
`define OFS_CONFIG 8'h00
`define OFS_TELEM 8'h04
`define OFS_VRSTAT 8'h08
`define OFS_CTRL 8'h0C
`define OFS_LINK 8'h10
// status bits
`define ERR_PARITY 0
`define ERR_CMD 1
`endif

// File: vr_serial_setpoint_command_port.v
// Purpose: slave end of the three-wire setpoint bus plus an AHB-Lite window
// Assumes: vr_bus_clock well below hclk/4; all link pins asynchronous
// Notes: master samples on rising link edges, we drive after falling ones
`timescale 1ns/1ps
`include "vr_setpoint_map.vh"
module vr_serial_setpoint_command_port #(
  parameter [7:0] VENDOR_CODE = 8'h5A,  // arbitrary value
  parameter [7:0] PRODUCT_CODE = 8'h3C, // arbitrary value
  parameter [7:0] REV_CODE = 8'h01      // arbitrary value
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire vr_bus_clock,
  input wire vr_bus_data_line_in,
  output reg vr_bus_data_line_out,
  output reg vr_bus_data_line_oe,
  input wire vr_bus_alert_in,
  output reg vr_bus_alert_out,
  output reg vr_bus_alert_oe,
  input wire [4:0] strap_code,
  output reg ext_sync_disable,
  output reg boost_disable,
  output reg [7:0] reference_setpoint_voltage
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_RECV = 4'h2;
  localparam [3:0] ST_TURN = 4'h4;
  localparam [3:0] ST_TX = 4'h8;
  // least step time rounds up to whole cycles
  localparam integer FAST_CYC = (`STEP_MV * 1000 + `FAST_RATE_MV_PER_US * `CLK_PERIOD_NS - 1)
                                / (`FAST_RATE_MV_PER_US * `CLK_PERIOD_NS);
  localparam integer SLOW_CYC = (`STEP_MV * 1000 + `SLOW_RATE_MV_PER_US * `CLK_PERIOD_NS - 1)
                                / (`SLOW_RATE_MV_PER_US * `CLK_PERIOD_NS);

  reg [2:0] clk_s_r;
  reg [1:0] din_s_r;
  reg [4:0] strap_s1_r;
  reg [4:0] strap_s2_r;
  reg [4:0] strap_r;
  reg [1:0] strap_cnt_r;
  reg strap_ok_r;
  reg [3:0] state_r;
  reg [4:0] bit_cnt_r;
  reg [16:0] rx_sh_r;
  reg [10:0] tx_sh_r;
  reg [3:0] tx_left_r;
  reg [7:0] pointer_r;
  reg [7:0] setting_r;
  reg [7:0] offset_r;
  reg [7:0] vboot_r;
  reg [7:0] iccmax_r;
  reg [7:0] tmax_r;
  reg [7:0] voutmax_r;
  reg [7:0] multi_r;
  reg [7:0] pstate_r;
  reg [1:0] stat2_r;
  reg [1:0] hist_r;
  reg rate_fast_r;
  reg ramp_arm_r; // alert armed only once a setpoint change started
  reg [3:0] step_cnt_r;
  reg alert_pend_r;
  reg [7:0] tzone_r;
  reg [7:0] iout0_r;
  reg [7:0] iout1_r;
  reg [5:0] sw_stat_r;
  reg dph_wr_r;
  reg [7:0] dph_ofs_r;
  reg [7:0] rd_val;
  reg [31:0] bus_rd;

  // link edges from the synchronised clock; stage 0 feeds only stage 1
  wire rise = clk_s_r[1] & ~clk_s_r[2];
  wire fall = ~clk_s_r[1] & clk_s_r[2];
  wire din = din_s_r[1];
  wire [17:0] rx_full = {rx_sh_r, din};
  wire [3:0] f_addr = rx_full[17:14];
  wire [4:0] f_cmd = rx_full[13:9];
  wire [7:0] f_pay = rx_full[8:1];
  wire [3:0] pair_base = {strap_r[4:2], 1'b0};
  wire last_bit = rise & state_r[1] & (bit_cnt_r == `FRAME_BITS - 5'h01);
  wire addr_hit = strap_ok_r & (({f_addr[3:1], 1'b0} == pair_base) ||
                  (f_addr == `ALLCALL_A) || (f_addr == `ALLCALL_B));
  wire par_ok = ~(^rx_full);
  wire no_par = (f_cmd == `CMD_PTR) || (f_cmd == `CMD_WRITE);
  // decay and trim stay outside the known set
  wire known = (f_cmd == `CMD_FAST) || (f_cmd == `CMD_SLOW) || (f_cmd == `CMD_PSTATE) ||
               no_par || (f_cmd == `CMD_READ);
  wire [9:0] ofs_sum = {2'b00, setting_r} + {{2{f_pay[7]}}, f_pay};
  // offset may not leave 0 V..1.52 V
  wire ofs_bad = (f_cmd == `CMD_WRITE) && (pointer_r == `REG_OFFSET) && (ofs_sum[9] | ofs_sum[8]);
  wire accept = addr_hit & known & (par_ok | no_par) & ~ofs_bad;
  wire is_read = f_cmd == `CMD_READ;
  wire rd_stat2 = last_bit & accept & is_read & (f_pay == `REG_STAT2);
  wire rd_stat1 = last_bit & accept & is_read & (f_pay == `REG_STAT1);
  wire [9:0] tgt_sum = {2'b00, setting_r} + {{2{offset_r[7]}}, offset_r};
  // target margined and clamped into code range
  wire [7:0] target = tgt_sum[9] ? 8'h00 : (tgt_sum[8] ? 8'hFF : tgt_sum[7:0]);
  wire settled = reference_setpoint_voltage == target;
  wire [3:0] step_lim = rate_fast_r ? FAST_CYC[3:0] : SLOW_CYC[3:0];
  wire reload = dph_wr_r & (dph_ofs_r == `OFS_CTRL) & hwdata[0];
  wire [7:0] stat1 = {sw_stat_r, alert_pend_r, settled};

  // register contents seen by a link read
  // read returns named register
  always @*
  begin
    case (f_pay)
      `REG_VENDOR: rd_val = VENDOR_CODE;
      `REG_PRODUCT: rd_val = PRODUCT_CODE;
      `REG_REV: rd_val = REV_CODE;
      `REG_PROTO: rd_val = `PROTO_VAL;
      `REG_CAPAB: rd_val = `CAPAB_VAL;
      `REG_STAT1: rd_val = stat1;
      `REG_STAT2: rd_val = {6'h00, stat2_r};
      `REG_TZONE: rd_val = tzone_r;
      `REG_IOUT0: rd_val = iout0_r;
      `REG_IOUT1: rd_val = iout1_r;
      `REG_HIST: rd_val = {6'h00, hist_r};
      `REG_ICCMAX: rd_val = iccmax_r;
      `REG_TMAX: rd_val = tmax_r;
      `REG_SRFAST: rd_val = `SRFAST_CODE;
      `REG_SRSLOW: rd_val = `SRSLOW_CODE;
      `REG_VBOOT: rd_val = vboot_r;
      `REG_VOUTMAX: rd_val = voutmax_r;
      `REG_SETTING: rd_val = setting_r;
      `REG_PSTATE: rd_val = pstate_r;
      `REG_OFFSET: rd_val = offset_r;
      `REG_MULTI: rd_val = multi_r;
      `REG_POINTER: rd_val = pointer_r;
      default: rd_val = 8'h00;
    endcase
  end

  // synchronisers and strap capture after reset release
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clk_s_r <= 3'h7; // idle-high link clock, so no false rise after reset
      din_s_r <= 2'h3;
      strap_s1_r <= 5'h00;
      strap_s2_r <= 5'h00;
      strap_r <= 5'h00;
      strap_cnt_r <= 2'h0;
      strap_ok_r <= 1'b0;
      ext_sync_disable <= 1'b0;
      boost_disable <= 1'b0;
    end
    else
    begin
      clk_s_r <= {clk_s_r[1:0], vr_bus_clock};
      din_s_r <= {din_s_r[0], vr_bus_data_line_in};
      strap_s1_r <= strap_code;
      strap_s2_r <= strap_s1_r;
      if (!strap_ok_r)
        strap_cnt_r <= strap_cnt_r + 2'h1;
      if (!strap_ok_r && strap_cnt_r == 2'h3)
      begin
        strap_r <= strap_s2_r;
        strap_ok_r <= 1'b1;
        ext_sync_disable <= strap_s2_r[1];
        boost_disable <= strap_s2_r[0];
      end
    end
  end

  // frame receive, decode and answer
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 5'h00;
      rx_sh_r <= 17'h00000;
      tx_sh_r <= 11'h000;
      tx_left_r <= 4'h0;
      vr_bus_data_line_out <= 1'b1;
      vr_bus_data_line_oe <= 1'b0;
      pointer_r <= 8'h00;
      setting_r <= `VBOOT_RST;
      offset_r <= 8'h00;
      vboot_r <= `VBOOT_RST;
      iccmax_r <= 8'h00;
      tmax_r <= 8'h00;
      voutmax_r <= 8'hFF;
      multi_r <= 8'h00;
      pstate_r <= 8'h00;
      rate_fast_r <= 1'b0;
      stat2_r <= 2'h0;
      hist_r <= 2'h0;
      alert_pend_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          // start bit: line low at a rising link edge
          if (rise && !din && strap_ok_r)
          begin
            state_r <= ST_RECV;
            bit_cnt_r <= 5'h00;
          end
        end
        ST_RECV:
        begin
          if (rise)
          begin
            rx_sh_r <= rx_full[16:0];
            bit_cnt_r <= bit_cnt_r + 5'h01;
          end
          if (last_bit)
          begin
            // foreign or refused frames get no drive
            state_r <= accept ? ST_TURN : ST_IDLE;
            tx_sh_r <= {`ACK_CODE, is_read ? rd_val : 8'h00, is_read ? ^rd_val : 1'b0};
            tx_left_r <= is_read ? `TX_BITS_READ : `TX_BITS_ACK;
          end
        end
        ST_TURN:
        begin
          // one link period of turnaround before we drive
          if (rise)
            state_r <= ST_TX;
        end
        ST_TX:
        begin
          if (fall)
          begin
            if (tx_left_r != 4'h0)
            begin
              vr_bus_data_line_oe <= 1'b1;
              vr_bus_data_line_out <= tx_sh_r[10];
              tx_sh_r <= {tx_sh_r[9:0], 1'b0};
              tx_left_r <= tx_left_r - 4'h1;
            end
            else
            begin
              vr_bus_data_line_oe <= 1'b0;
              vr_bus_data_line_out <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase

      // command effects on accepted frames
      if (last_bit && accept)
      begin
        case (f_cmd)
          `CMD_FAST:
          begin
            setting_r <= f_pay;
            rate_fast_r <= 1'b1;
          end
          `CMD_SLOW:
          begin
            setting_r <= f_pay;
            rate_fast_r <= 1'b0;
          end
          `CMD_PSTATE: pstate_r <= f_pay;
          `CMD_PTR: pointer_r <= f_pay;
          `CMD_WRITE:
          begin
            case (pointer_r)
              `REG_VBOOT: vboot_r <= f_pay;
              `REG_ICCMAX: iccmax_r <= f_pay;
              `REG_TMAX: tmax_r <= f_pay;
              `REG_VOUTMAX: voutmax_r <= f_pay;
              `REG_OFFSET: offset_r <= f_pay;
              `REG_MULTI: multi_r <= f_pay;
              `REG_POINTER: pointer_r <= f_pay;
              default: pointer_r <= pointer_r;
            endcase
          end
          default: pointer_r <= pointer_r;
        endcase
      end
      else if (reload)
        setting_r <= vboot_r;

      // errors sticky, read copies then clears; set wins
      if (rd_stat2)
        hist_r <= stat2_r;
      stat2_r[`ERR_PARITY] <= (stat2_r[`ERR_PARITY] & ~rd_stat2) |
                              (last_bit & addr_hit & ~par_ok & ~no_par);
      stat2_r[`ERR_CMD] <= (stat2_r[`ERR_CMD] & ~rd_stat2) | (last_bit & addr_hit & ~known);

      // alert per change, new change may re-arm it
      if (last_bit && accept && (f_cmd == `CMD_FAST || f_cmd == `CMD_SLOW))
        alert_pend_r <= 1'b0;
      else if (rd_stat1)
        alert_pend_r <= 1'b0;
      else if (settled && step_cnt_r == 4'h0 && vr_bus_alert_oe == 1'b0 && ramp_arm_r)
        alert_pend_r <= 1'b1;
    end
  end

  // reference walks one code per step period
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reference_setpoint_voltage <= `VBOOT_RST;
      step_cnt_r <= 4'h0;
      ramp_arm_r <= 1'b0;
      vr_bus_alert_oe <= 1'b0;
      vr_bus_alert_out <= 1'b0;
    end
    else
    begin
      if (settled)
        step_cnt_r <= 4'h0;
      else if (step_cnt_r >= step_lim - 4'h1)
      begin
        step_cnt_r <= 4'h0;
        if (reference_setpoint_voltage < target)
          reference_setpoint_voltage <= reference_setpoint_voltage + 8'h01;
        else
          reference_setpoint_voltage <= reference_setpoint_voltage - 8'h01;
      end
      else
        step_cnt_r <= step_cnt_r + 4'h1;
      if (last_bit && accept && (f_cmd == `CMD_FAST || f_cmd == `CMD_SLOW))
        ramp_arm_r <= 1'b1;
      else if (alert_pend_r)
        ramp_arm_r <= 1'b0;
      // open-drain alert pulled low while pending
      vr_bus_alert_oe <= alert_pend_r;
    end
  end

  // AHB-Lite slave: zero wait, always OKAY
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      dph_wr_r <= 1'b0;
      dph_ofs_r <= 8'h00;
      tzone_r <= 8'h00;
      iout0_r <= 8'h00;
      iout1_r <= 8'h00;
      sw_stat_r <= 6'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dph_wr_r <= hsel & htrans[1] & hwrite & hready;
      dph_ofs_r <= haddr[7:0];
      if (hsel && htrans[1] && !hwrite && hready)
        hrdata <= (haddr[31:8] == 24'h000000) ? bus_rd : 32'h00000000;
      if (dph_wr_r && dph_ofs_r == `OFS_TELEM)
      begin
        tzone_r <= hwdata[7:0];
        iout0_r <= hwdata[15:8];
        iout1_r <= hwdata[23:16];
      end
      if (dph_wr_r && dph_ofs_r == `OFS_VRSTAT)
        sw_stat_r <= hwdata[7:2];
    end
  end

  // read view of the bus registers; unmapped reads zero
  always @*
  begin
    case (haddr[7:0])
      `OFS_CONFIG: bus_rd = {setting_r, reference_setpoint_voltage, 7'h00, strap_ok_r,
                             3'h0, strap_r};
      `OFS_TELEM: bus_rd = {8'h00, iout1_r, iout0_r, tzone_r};
      `OFS_VRSTAT: bus_rd = {24'h000000, stat1};
      `OFS_LINK: bus_rd = {pointer_r, pstate_r, 4'h0, hist_r, stat2_r, offset_r};
      default: bus_rd = 32'h00000000;
    endcase
  end
endmodule // vr_serial_setpoint_command_port

// File: vr_link_master.sv
// Purpose: processor side of the three-wire setpoint link
// Assumes: line is the resolved wire, pulled high when nobody drives it
// Notes: clock rests high between frames; 800 ns link period
`timescale 1ns/1ps
module vr_link_master (
  output logic link_clk,
  output logic drv,
  output logic drv_oe,
  input wire line,
  output logic [10:0] rx,
  output logic rx_done
);
  initial
  begin
    link_clk = 1'b1;
    drv = 1'b1;
    drv_oe = 1'b0;
    rx = 11'h000;
    rx_done = 1'b0;
  end

  // one link period; answer bits are taken at the rising edge
  task tick(input logic smp);
    link_clk = 1'b0;
    #400;
    link_clk = 1'b1;
    if (smp)
      rx = {rx[9:0], line};
    #400;
  endtask

  // start bit, then address, command, payload and even parity
  task frame(input logic [16:0] w, input logic bad, input int n);
    logic [18:0] f;
    int i;
    f = {1'b0, w, ^w ^ bad};
    rx = 11'h000;
    drv_oe = 1'b1;
    for (i = 18; i >= 0; i--)
    begin
      drv = f[i];
      tick(1'b0);
    end
    // released: inverse level kept inside, the wire shows the pull-up
    drv_oe = 1'b0;
    drv = ~drv;
    tick(1'b0);
    for (i = 0; i < n; i++)
      tick(1'b1);
    tick(1'b0);
    rx_done = 1'b1;
    #1;
    rx_done = 1'b0;
  endtask
endmodule // vr_link_master

// File: vr_serial_setpoint_command_port_sva.sv
// Purpose: port properties of the setpoint command port
// Assumes: one clock domain, hresetn asynchronous active low
// Notes: strap checks wait until the capture has surely happened
`timescale 1ns/1ps
module vr_port_checker (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire vr_bus_clock,
  input wire vr_bus_data_line_oe,
  input wire vr_bus_alert_out,
  input wire vr_bus_alert_oe,
  input wire [4:0] strap_code,
  input wire ext_sync_disable,
  input wire boost_disable,
  input wire [7:0] reference_setpoint_voltage
);
  reg [3:0] up_r;
  wire [7:0] rc = reference_setpoint_voltage;

  // cycles since reset, saturating
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      up_r <= 4'h0;
    else if (up_r != 4'hF)
      up_r <= up_r + 4'h1;
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  zero_wait_a: assert property (up_r > 4'h1 |-> hreadyout)
    else $error("hreadyout low in operation");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  sync_strap_a: assert property (up_r == 4'hF |-> ext_sync_disable == strap_code[1])
    else $error("sync option differs from strap");
  boost_strap_a: assert property (up_r == 4'hF |-> boost_disable == strap_code[0])
    else $error("boost option differs from strap");
  strap_read_a: assert property (hsel && htrans[1] && hready && !hwrite && haddr == 32'h0
    && up_r == 4'hF |=> hrdata[4:0] == strap_code && hrdata[8]) else $error("strap readback wrong");
  ref_step_a: assert property (rc != $past(rc) |-> rc == $past(rc) + 8'h01
    || rc == $past(rc) - 8'h01) else $error("reference jumped");
  ref_spacing_a: assert property (rc != $past(rc) |=> $stable(rc) [*2])
    else $error("reference steps too close");
  drive_after_fall_a: assert property ($rose(vr_bus_data_line_oe) |-> !vr_bus_clock)
    else $error("data driven outside low clock phase");
  alert_low_a: assert property (vr_bus_alert_oe |-> !vr_bus_alert_out)
    else $error("alert driven high");

  cover property (rc != $past(rc));
  cover property ($rose(vr_bus_data_line_oe));
  cover property ($rose(vr_bus_alert_oe));
endmodule // vr_port_checker

bind vr_serial_setpoint_command_port vr_port_checker i_vr_port_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .vr_bus_clock(vr_bus_clock), .vr_bus_data_line_oe(vr_bus_data_line_oe),
  .vr_bus_alert_out(vr_bus_alert_out), .vr_bus_alert_oe(vr_bus_alert_oe),
  .strap_code(strap_code), .ext_sync_disable(ext_sync_disable), .boost_disable(boost_disable),
  .reference_setpoint_voltage(reference_setpoint_voltage)
);

// File: vr_serial_setpoint_command_port_tb.sv
// Purpose: self-checking bench for the setpoint command port
// Assumes: one AHB-Lite master and the link master model
// Notes: expected results queue per source, compared as they appear
`timescale 1ns/1ps
`include "vr_setpoint_map.vh"
module vr_serial_setpoint_command_port_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [4:0] strap_code = 5'h00;
  wire hreadyout, hresp, d_oe, d_out, al_oe, al_out, ext_sync_disable, boost_disable;
  wire link_clk, drv, drv_oe, rx_done;
  wire [31:0] hrdata;
  wire [7:0] rc;
  wire [10:0] rx;
  // open-drain wires: low only where an enabled party drives low
  wire line = (d_oe ? d_out : 1'b1) & (drv_oe ? drv : 1'b1);
  wire al_line = al_oe ? al_out : 1'b1;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [63:0] ahb_q[$];
  logic [10:0] link_q[$];
  logic rd_ph = 1'b0;
  logic [3:0] a0, fa;
  logic [7:0] tg;
  logic [31:0] rv;
  logic [7:0] ev [0:9];
  logic [7:0] rp [0:9] = '{`REG_VENDOR, `REG_PRODUCT, `REG_REV, `REG_PROTO, `REG_CAPAB,
    `REG_SRFAST, `REG_SRSLOW, `REG_TZONE, `REG_IOUT0, `REG_IOUT1};

  always #50 hclk = ~hclk;

  // identity codes below are arbitrary values
  vr_serial_setpoint_command_port #(.VENDOR_CODE(8'h21), .PRODUCT_CODE(8'h43),
    .REV_CODE(8'h07)) i_vr_serial_setpoint_command_port (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .vr_bus_clock(link_clk),
    .vr_bus_data_line_in(line), .vr_bus_data_line_out(d_out), .vr_bus_data_line_oe(d_oe),
    .vr_bus_alert_in(al_line), .vr_bus_alert_out(al_out), .vr_bus_alert_oe(al_oe),
    .strap_code(strap_code), .ext_sync_disable(ext_sync_disable),
    .boost_disable(boost_disable), .reference_setpoint_voltage(rc));

  vr_link_master i_vr_link_master (.link_clk(link_clk), .drv(drv), .drv_oe(drv_oe),
    .line(line), .rx(rx), .rx_done(rx_done));

  task complete_run();
    if (errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [10:0] rd(input logic [7:0] v);
    rd = {2'b01, v, ^v};
  endfunction

  // single transfer; address phase held until hready, then data phase
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    if (!w)
      ahb_q.push_back({m, d & m});
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  // link command; a read answer is eleven bits, anything else two
  task lk(input logic [3:0] a, input logic [4:0] c, input logic [7:0] p, input logic bad,
    input logic [10:0] e);
    link_q.push_back(e);
    #37;
    i_vr_link_master.frame({a, c, p}, bad, (e[10:9] == 2'b01) ? 11 : 2);
    #800;
  endtask

  // cycles between two successive reference steps
  task rate(input int e);
    int n;
    logic [7:0] v;
    @(rc);
    v = rc;
    n = 0;
    do
    begin
      @(posedge hclk);
      #1;
      n++;
    end
    while (rc === v && n < 40);
    chk("ramp step cycles", e, n);
  endtask

  task wait_ref(input logic [7:0] v);
    while (rc !== v)
      @(posedge hclk);
  endtask

  // read data stands in the data phase, one edge after the address
  always @(posedge hclk)
  begin
    if (rd_ph && hreadyout)
    begin
      chk("hrdata", ahb_q[0][31:0], hrdata & ahb_q[0][63:32]);
      void'(ahb_q.pop_front());
    end
    rd_ph <= hsel && htrans[1] && hreadyout && !hwrite;
  end

  // link answers compared as the model finishes each frame
  always @(posedge rx_done)
  begin
    chk("link answer", {21'h0, link_q[0]}, {21'h0, rx});
    void'(link_q.pop_front());
  end

  // cut a hang short
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      complete_run();
    end
  end

  initial
  begin
    rv = $urandom(89984);
    strap_code = $urandom % 28;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    a0 = {strap_code[4:2], 1'b0};
    fa = (a0 == 4'hC) ? 4'h0 : a0 + 4'h2;
    repeat (6) @(posedge hclk);
    ahb(1'b0, `OFS_CONFIG, {23'h0, 1'b1, 3'h0, strap_code}, 32'hFFFF_011F);
    chk("options", {30'h0, strap_code[1:0]}, {30'h0, ext_sync_disable, boost_disable});
    rv = $urandom;
    ahb(1'b1, `OFS_TELEM, rv, 32'h0);
    ahb(1'b0, `OFS_TELEM, rv, 32'h00FF_FFFF);
    ahb(1'b0, 8'h2C, 32'h0, 32'hFFFF_FFFF);
    ev = '{8'h21, 8'h43, 8'h07, `PROTO_VAL, `CAPAB_VAL, 8'h14, 8'h05, rv[7:0], rv[15:8],
      rv[23:16]};
    for (int i = 0; i < 10; i++)
      lk({a0[3:1], i[0]}, `CMD_READ, rp[i], 1'b0, rd(ev[i]));
    lk(fa, `CMD_READ, `REG_PROTO, 1'b0, 11'h003);
    tg = {6'h0, rv[25:24]};
    lk(4'hE, `CMD_PSTATE, tg, 1'b0, 11'h001);
    lk(4'hF, `CMD_READ, `REG_PSTATE, 1'b0, rd(tg));
    lk(a0, `CMD_PTR, `REG_VBOOT, 1'b1, 11'h001);
    lk(a0, `CMD_WRITE, 8'h40, 1'b1, 11'h001);
    lk(a0, `CMD_READ, `REG_VBOOT, 1'b0, rd(8'h40));
    lk(a0, `CMD_FAST, 8'h30, 1'b1, 11'h003);
    lk(a0, `CMD_DECAY, 8'h30, 1'b0, 11'h003);
    lk(a0, `CMD_TRIM, 8'h00, 1'b0, 11'h003);
    chk("reference", 32'h0, {24'h0, rc});
    lk(a0, `CMD_READ, `REG_STAT2, 1'b0, rd(8'h03));
    lk(a0, `CMD_READ, `REG_HIST, 1'b0, rd(8'h03));
    lk(a0, `CMD_READ, `REG_STAT2, 1'b0, rd(8'h00));
    tg = 8'h20 + ($urandom % 32);
    lk(a0 + 4'h1, `CMD_FAST, tg, 1'b0, 11'h001);
    rate(3);
    wait_ref(tg);
    repeat (4) @(posedge hclk);
    chk("alert", 32'h1, {31'h0, al_oe});
    lk(a0, `CMD_SLOW, tg - 8'h10, 1'b0, 11'h001);
    chk("alert", 32'h0, {31'h0, al_oe});
    rate(10);
    wait_ref(tg - 8'h10);
    lk(a0, `CMD_PTR, `REG_OFFSET, 1'b0, 11'h001);
    lk(a0, `CMD_WRITE, 8'h80, 1'b0, 11'h003);
    lk(a0, `CMD_WRITE, 8'h02, 1'b0, 11'h001);
    ahb(1'b0, `OFS_LINK, 32'h02, 32'hFF);
    wait_ref(tg - 8'h0E);
    ahb(1'b1, `OFS_CTRL, 32'h1, 32'h0);
    ahb(1'b0, `OFS_CONFIG, 32'h4000_0100, 32'hFF00_0100);
    repeat (2) @(posedge hclk);
    complete_run();
  end
endmodule // vr_serial_setpoint_command_port_tb
